/* hw/flash_host_map.svh */
// constants for the page-write flash host controller
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// command addresses and codes
`define FH_ADDR_5555 16'h5555
`define FH_ADDR_2AAA 16'h2aaa
`define FH_CODE_AA 8'haa
`define FH_CODE_55 8'h55
`define FH_CODE_PROT 8'ha0
`define FH_CODE_EXT 8'h80
`define FH_CODE_UNPROT 8'h20
`define FH_CODE_ERASE 8'h10
`define FH_CODE_ID3 8'h90
`define FH_CODE_ID6 8'h60
`define FH_CODE_IDEXIT 8'hf0
// page layout
`define FH_PAGE_BYTES 128
`define FH_OFFS_BITS 7
`define FH_ERASED 8'hff
`define FH_POLL_BIT 7
`define FH_TOGGLE_BIT 6
// clock and times
`define FH_CLK_NS 10
`define FH_WE_MIN_NS 15
`define FH_WE_CYC ((`FH_WE_MIN_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_ACC_NS 120
`define FH_RD_CYC ((`FH_ACC_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_PAUSE_US 10
`define FH_PAUSE_CYC ((`FH_PAUSE_US * 1000 + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WIN_US 150
`define FH_WIN_CYC ((`FH_WIN_US * 1000) / `FH_CLK_NS)
`define FH_PROG_MS 10
`define FH_PROG_CYC ((`FH_PROG_MS * 1000000) / `FH_CLK_NS)
`define FH_ERASE_MS 50
`define FH_ERASE_CYC ((`FH_ERASE_MS * 1000000) / `FH_CLK_NS)

`endif

/* hw/flash_host_pkg.sv */
// types for the page-write flash host controller
package flash_host_pkg;
    // operations offered on the command port
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PAGE = 3'h1,
        OP_ERASE = 3'h2,
        OP_UNPROT = 3'h3,
        OP_ID_ENTER = 3'h4,
        OP_ID_ENTER6 = 3'h5,
        OP_ID_EXIT = 3'h6,
        OP_HWID = 3'h7
    } op_t;
endpackage

/* hw/flash_bus_if.sv */
// request carrier between sequencer and pin cycle engine
`timescale 1ns/1ps
interface flash_bus_if;
    logic req; // one-cycle request pulse
    logic wr; // write when high, read when low
    logic [15:0] addr; // cycle address
    logic [7:0] wdata; // write data
    logic done; // one-cycle completion pulse
    logic [7:0] rdata; // read result, valid with done
    modport master (output req, output wr, output addr, output wdata,
                    input done, input rdata);
    modport engine (input req, input wr, input addr, input wdata,
                    output done, output rdata);
endinterface

/* hw/flash_cycle.sv */
// single read or write cycle on the flash pins
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_cycle import flash_host_pkg::*; #(
    parameter int WE_CYC = `FH_WE_CYC,
    parameter int RD_CYC = `FH_RD_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // request side
    flash_bus_if.engine bus,
    // flash pins
    output logic [15:0] addr_r,
    output logic [7:0] dq_out_r,
    output logic dq_oe_r,
    input wire logic [7:0] dq_in,
    output logic ce_n_r,
    output logic oe_n_r,
    output logic we_n_r
);
    typedef enum logic [4:0] {
        C_IDLE = 5'b00001,
        C_SETUP = 5'b00010,
        C_STROBE = 5'b00100,
        C_HOLD = 5'b01000,
        C_READ = 5'b10000
    } cyc_t;

    cyc_t st_r; // cycle state
    logic wr_r; // latched direction
    logic [7:0] cnt_r; // strobe and access counter
    logic [7:0] dq_s1_r, dq_s2_r, dq_s3_r; // pin synchroniser

    // data pins come from outside the clock domain
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
            dq_s3_r <= 8'h00;
        end else begin
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
            dq_s3_r <= dq_s2_r;
        end
    end

    // pin sequencing; address settles a cycle before any strobe falls
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= C_IDLE;
            wr_r <= 1'b0;
            cnt_r <= 8'h00;
            addr_r <= 16'h0000;
            dq_out_r <= 8'h00;
            dq_oe_r <= 1'b0;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            bus.done <= 1'b0;
            bus.rdata <= 8'h00;
        end else begin
            bus.done <= 1'b0;
            case (st_r)
                C_IDLE: begin
                    if (bus.req) begin
                        addr_r <= bus.addr;
                        dq_out_r <= bus.wdata;
                        wr_r <= bus.wr;
                        st_r <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    cnt_r <= 8'h00;
                    ce_n_r <= 1'b0;
                    if (wr_r) begin
                        // R03 - write with oe high
                        oe_n_r <= 1'b1;
                        we_n_r <= 1'b0;
                        dq_oe_r <= 1'b1;
                        st_r <= C_STROBE;
                    end else begin
                        oe_n_r <= 1'b0;
                        st_r <= C_READ;
                    end
                end
                C_STROBE: begin
                    // R14 - strobe longer than glitch
                    if (cnt_r == 8'(WE_CYC - 1)) begin
                        we_n_r <= 1'b1;
                        ce_n_r <= 1'b1;
                        st_r <= C_HOLD;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                C_HOLD: begin
                    // data held one cycle past the rising strobes
                    dq_oe_r <= 1'b0;
                    bus.done <= 1'b1;
                    st_r <= C_IDLE;
                end
                C_READ: begin
                    // wait out access time, then take a stable byte
                    if (cnt_r < 8'(RD_CYC + 3)) begin
                        cnt_r <= cnt_r + 8'h01;
                    end else if (dq_s2_r == dq_s3_r) begin
                        bus.rdata <= dq_s3_r;
                        bus.done <= 1'b1;
                        ce_n_r <= 1'b1;
                        oe_n_r <= 1'b1;
                        st_r <= C_IDLE;
                    end
                end
                default: st_r <= C_IDLE;
            endcase
        end
    end

    // a_we_width R14 write strobe width
    a_we_width: assert property (@(posedge clock) disable iff (sys_rst) // R14
        $fell(we_n_r) |-> (!we_n_r && !ce_n_r)[*2] ##1 we_n_r)
        else $error("write strobe shorter than two cycles");
    // a_write_oe_high R03
    a_write_oe_high: assert property (@(posedge clock) disable iff (sys_rst) // R03
        !we_n_r |-> (oe_n_r && !ce_n_r && dq_oe_r))
        else $error("write strobe low without oe high and ce low");
    // a_bus_release R01
    a_bus_release: assert property (@(posedge clock) disable iff (sys_rst) // R01
        !oe_n_r |-> !dq_oe_r)
        else $error("host drives data while flash outputs enabled");
    // a_addr_stable R04
    a_addr_stable: assert property (@(posedge clock) disable iff (sys_rst) // R04
        (!ce_n_r && !$past(ce_n_r)) |-> $stable(addr_r))
        else $error("address moved during a cycle");
endmodule // flash_cycle

/* hw/flash_host.sv */
// host sequencer for a byte-wide page-write flash
`timescale 1ns/1ps
`include "flash_host_map.svh"
// Operation
// R01 - flash drives data only when selected
// R02 - unloaded page bytes program to FFh
// R03 - write: ce low, we low, oe high
// R04 - address latched on first falling strobe; the model latches on the last
// R05 - next byte within 150 us window
// R06 - window expiry starts internal programming
// R07 - page from A15..A7, one page
// R08 - bytes may load in any order
// R09 - whole page programs at once
// R10 - protected load needs three-byte preamble
// R11 - preamble enables protection, shipped protected
// R12 - protection kept across power cycles
// R13 - six-byte sequence disables protection
// R14 - strobes under 15 ns ignored
// R15 - oe low or strobes high inhibit
// R16 - polling bit inverted while programming
// R17 - toggle bit alternates while programming
// R18 - chip erase done within 50 ms
// R19 - six-byte chip erase command
// R20 - id mode maps 0000H, 0001H
// R21 - three-byte exit ends id mode
// R22 - id entry/exit codes, 10 us pause
// R23 - high voltage on id pin reads id
// R24 - host polls completion before next command
module flash_host import flash_host_pkg::*; #(
    parameter int WIN_CYC = `FH_WIN_CYC,
    parameter int PAUSE_CYC = `FH_PAUSE_CYC,
    parameter int PROG_CYC = `FH_PROG_CYC,
    parameter int ERASE_CYC = `FH_ERASE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // command port
    input wire logic cmd_valid,
    input wire op_t cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic cmd_protect,
    output logic cmd_ready_r,
    // page byte stream
    input wire logic byte_valid,
    input wire logic [6:0] byte_offs,
    input wire logic [7:0] byte_data,
    input wire logic byte_last,
    output logic byte_ready_r,
    // results
    output logic done_r,
    output logic [7:0] rdata_r,
    output logic timeout_r,
    // flash pins
    output logic [15:0] addr_r,
    output logic [7:0] dq_out_r,
    output logic dq_oe_r,
    input wire logic [7:0] dq_in,
    output logic ce_n_r,
    output logic oe_n_r,
    output logic we_n_r,
    output logic id_hv_en_r
);
    typedef enum logic [6:0] {
        M_IDLE = 7'b0000001,
        M_SEQ = 7'b0000010,
        M_LOAD = 7'b0000100,
        M_READ = 7'b0001000,
        M_POLL = 7'b0010000,
        M_PAUSE = 7'b0100000,
        M_DONE = 7'b1000000
    } main_t;

    flash_bus_if bus ();

    main_t st_r; // sequencer state
    op_t op_r; // operation in progress
    logic [15:0] cad_r; // command address
    logic [2:0] len_r; // preamble length
    logic [2:0] idx_r; // preamble index
    logic wait_r; // cycle outstanding
    logic [31:0] tmr_r; // window, pause and timeout counter
    logic [15:0] last_a_r; // address of last loaded byte
    logic exp7_r; // true polling bit
    logic [7:0] prev_r; // previous poll read
    logic have_prev_r; // prev_r holds a read
    logic fin_r; // last byte already issued
    logic req_r, wr_r; // request fields
    logic [15:0] raddr_r;
    logic [7:0] wdata_r;

    // number of command bytes before the operation
    function automatic logic [2:0] seq_len(input op_t op, input logic prot);
        case (op)
            OP_PAGE: seq_len = prot ? 3'd3 : 3'd0;
            OP_ERASE, OP_UNPROT, OP_ID_ENTER6: seq_len = 3'd6;
            OP_ID_ENTER, OP_ID_EXIT: seq_len = 3'd3;
            default: seq_len = 3'd0;
        endcase
    endfunction

    // address and data of one command byte
    function automatic logic [23:0] seq_word(input op_t op, input logic [2:0] i);
        logic [7:0] third;
        logic [7:0] last;
        third = `FH_CODE_EXT;
        last = `FH_CODE_ERASE;
        if (op == OP_PAGE) third = `FH_CODE_PROT;
        if (op == OP_ID_ENTER) third = `FH_CODE_ID3;
        if (op == OP_ID_EXIT) third = `FH_CODE_IDEXIT;
        if (op == OP_UNPROT) last = `FH_CODE_UNPROT;
        if (op == OP_ID_ENTER6) last = `FH_CODE_ID6;
        case (i)
            3'd0, 3'd3: seq_word = {`FH_ADDR_5555, `FH_CODE_AA};
            3'd1, 3'd4: seq_word = {`FH_ADDR_2AAA, `FH_CODE_55};
            3'd2: seq_word = {`FH_ADDR_5555, third};
            default: seq_word = {`FH_ADDR_5555, last};
        endcase
    endfunction

    assign bus.req = req_r;
    assign bus.wr = wr_r;
    assign bus.addr = raddr_r;
    assign bus.wdata = wdata_r;

    // pin cycle engine
    flash_cycle u_cycle (
        .clock(clock),
        .sys_rst(sys_rst),
        .bus(bus.engine),
        .addr_r(addr_r),
        .dq_out_r(dq_out_r),
        .dq_oe_r(dq_oe_r),
        .dq_in(dq_in),
        .ce_n_r(ce_n_r),
        .oe_n_r(oe_n_r),
        .we_n_r(we_n_r)
    );

    // sequencer; one bus cycle outstanding at a time
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= M_IDLE;
            op_r <= OP_READ;
            cad_r <= 16'h0000;
            len_r <= 3'd0;
            idx_r <= 3'd0;
            wait_r <= 1'b0;
            tmr_r <= 32'h0000_0000;
            last_a_r <= 16'h0000;
            exp7_r <= 1'b1;
            prev_r <= 8'h00;
            have_prev_r <= 1'b0;
            fin_r <= 1'b0;
            req_r <= 1'b0;
            wr_r <= 1'b0;
            raddr_r <= 16'h0000;
            wdata_r <= 8'h00;
            cmd_ready_r <= 1'b1;
            byte_ready_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            timeout_r <= 1'b0;
            id_hv_en_r <= 1'b0;
        end else begin
            req_r <= 1'b0;
            done_r <= 1'b0;
            byte_ready_r <= 1'b0;
            if (bus.done) wait_r <= 1'b0;
            case (st_r)
                M_IDLE: begin
                    if (cmd_valid) begin
                        cmd_ready_r <= 1'b0;
                        op_r <= cmd_op;
                        cad_r <= cmd_addr;
                        len_r <= seq_len(cmd_op, cmd_protect);
                        idx_r <= 3'd0;
                        tmr_r <= 32'h0000_0000;
                        timeout_r <= 1'b0;
                        have_prev_r <= 1'b0;
                        fin_r <= 1'b0;
                        if (seq_len(cmd_op, cmd_protect) != 3'd0) st_r <= M_SEQ;
                        else if (cmd_op == OP_PAGE) st_r <= M_LOAD;
                        else st_r <= M_READ;
                        // R23 - raise id pin for hardware id
                        id_hv_en_r <= (cmd_op == OP_HWID);
                    end
                end
                M_SEQ: begin
                    // R10 R13 R19 R22 - command byte sequences
                    if (!wait_r && !req_r) begin
                        {raddr_r, wdata_r} <= seq_word(op_r, idx_r);
                        wr_r <= 1'b1;
                        req_r <= 1'b1;
                        wait_r <= 1'b1;
                    end else if (bus.done) begin
                        idx_r <= idx_r + 3'd1;
                        tmr_r <= 32'h0000_0000;
                        if (idx_r == len_r - 3'd1) begin
                            if (op_r == OP_PAGE) st_r <= M_LOAD;
                            else if (op_r == OP_ERASE) begin
                                // R02 - erased array polls as FFh
                                last_a_r <= 16'h0000;
                                exp7_r <= 1'(`FH_ERASED >> `FH_POLL_BIT);
                                st_r <= M_POLL;
                            end else st_r <= M_PAUSE;
                        end
                    end
                end
                M_LOAD: begin
                    tmr_r <= tmr_r + 32'd1;
                    if (!wait_r && !req_r && !fin_r) byte_ready_r <= 1'b1;
                    // R07 R08 - page from command, offset from stream
                    if (byte_ready_r && byte_valid) begin
                        raddr_r <= {cad_r[15:`FH_OFFS_BITS], byte_offs};
                        last_a_r <= {cad_r[15:`FH_OFFS_BITS], byte_offs};
                        wdata_r <= byte_data;
                        exp7_r <= byte_data[`FH_POLL_BIT];
                        wr_r <= 1'b1;
                        req_r <= 1'b1;
                        wait_r <= 1'b1;
                        fin_r <= byte_last;
                        byte_ready_r <= 1'b0;
                    end else if (bus.done) begin
                        // R05 - window restarts at each load
                        tmr_r <= 32'h0000_0000;
                        if (fin_r) st_r <= M_POLL;
                    end else if (!wait_r && tmr_r >= 32'(WIN_CYC - 1)) begin
                        // R06 - late byte means programming began
                        byte_ready_r <= 1'b0;
                        tmr_r <= 32'h0000_0000;
                        st_r <= M_POLL;
                    end
                end
                M_READ: begin
                    if (!wait_r && !req_r) begin
                        // R20 - low address bit picks id code
                        raddr_r <= (op_r == OP_HWID) ? {15'h0000, cad_r[0]} : cad_r;
                        wr_r <= 1'b0;
                        req_r <= 1'b1;
                        wait_r <= 1'b1;
                    end else if (bus.done) begin
                        rdata_r <= bus.rdata;
                        st_r <= M_DONE;
                    end
                end
                M_POLL: begin
                    // R24 R16 R17 - poll until toggling stops
                    tmr_r <= tmr_r + 32'd1;
                    if (!wait_r && !req_r && !timeout_r) begin
                        raddr_r <= last_a_r;
                        wr_r <= 1'b0;
                        req_r <= 1'b1;
                        wait_r <= 1'b1;
                    end else if (bus.done) begin
                        prev_r <= bus.rdata;
                        have_prev_r <= 1'b1;
                        if (have_prev_r
                            && bus.rdata[`FH_TOGGLE_BIT] == prev_r[`FH_TOGGLE_BIT]
                            && bus.rdata[`FH_POLL_BIT] == exp7_r) begin
                            rdata_r <= bus.rdata;
                            st_r <= M_DONE;
                        end
                    end
                    // R09 R18 - bounded wait for the internal cycle
                    if (tmr_r >= ((op_r == OP_ERASE) ? 32'(ERASE_CYC) : 32'(PROG_CYC))) begin
                        timeout_r <= 1'b1;
                        if (timeout_r && !wait_r) st_r <= M_DONE;
                    end
                end
                M_PAUSE: begin
                    // R21 R22 - settle after id or unprotect sequences
                    tmr_r <= tmr_r + 32'd1;
                    if (tmr_r >= 32'(PAUSE_CYC - 1)) st_r <= M_DONE;
                end
                M_DONE: begin
                    done_r <= 1'b1;
                    cmd_ready_r <= 1'b1;
                    id_hv_en_r <= 1'b0;
                    st_r <= M_IDLE;
                end
                default: st_r <= M_IDLE;
            endcase
        end
    end

    // helper: cycles spent in pause
    logic [31:0] pause_len_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) pause_len_r <= 32'h0000_0000;
        else if (st_r == M_PAUSE) pause_len_r <= pause_len_r + 32'd1;
        else pause_len_r <= 32'h0000_0000;
    end

    sequence s_cmd_start;
        st_r == M_IDLE && cmd_valid;
    endsequence
    sequence s_first_byte_aa;
        ##[1:40] (!we_n_r && dq_out_r == `FH_CODE_AA && addr_r == `FH_ADDR_5555);
    endsequence

    // a_pause_len R22 ten microsecond pause
    a_pause_len: assert property (@(posedge clock) disable iff (sys_rst) // R22
        (st_r == M_PAUSE && $past(st_r) == M_PAUSE && pause_len_r < 32'(PAUSE_CYC - 1))
        |-> ##1 st_r == M_PAUSE)
        else $error("pause left early");
    // a_preamble_first R10
    a_preamble_first: assert property (@(posedge clock) disable iff (sys_rst) // R10
        (s_cmd_start and (cmd_op == OP_PAGE && cmd_protect)) |-> s_first_byte_aa)
        else $error("protected load without preamble first byte");
    // a_hv_read_only R23
    a_hv_read_only: assert property (@(posedge clock) disable iff (sys_rst) // R23
        id_hv_en_r |-> we_n_r)
        else $error("write strobe while id voltage raised");
    // a_poll_no_write R24
    a_poll_no_write: assert property (@(posedge clock) disable iff (sys_rst) // R24
        st_r == M_POLL |-> we_n_r)
        else $error("write issued while polling");
    // a_done_pulse R24
    a_done_pulse: assert property (@(posedge clock) disable iff (sys_rst) // R24
        done_r |=> !done_r && cmd_ready_r)
        else $error("done not a single pulse");
    // a_load_page R07
    a_load_page: assert property (@(posedge clock) disable iff (sys_rst) // R07
        (st_r == M_LOAD && !we_n_r) |-> addr_r[15:7] == cad_r[15:7])
        else $error("byte load outside command page");
endmodule // flash_host

/* sim/flash_dev_model.sv */
// behavioural page-write flash standing at the far side of the host
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int WIN = 150,
    parameter int PROG = 300,
    parameter logic [7:0] MAKER = 8'h3c, // arbitrary code
    parameter logic [7:0] PART = 8'h5a // arbitrary code
) (
    // timer clock
    input wire logic clock,
    // flash pins
    input wire logic [15:0] addr,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    output logic [7:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic id_hv
);
    logic [7:0] mem [0:65535];
    logic [7:0] pbuf [0:127];
    logic [7:0] held = 8'h0;
    logic [7:0] last_d = 8'hff;
    logic [15:0] la = 16'h0;
    logic [15:0] last_a = 16'h0;
    logic [59:0] h = 60'h0; // last six command keys
    logic [9:0] key;
    logic prot = 1'b1; // shipped protected
    logic open = 1'b0;
    logic idm = 1'b0;
    logic tog = 1'b0;
    int busy = 0;
    int win = 0;
    realtime t0 = 0.0;
    wire wr_n = ce_n | we_n | !oe_n;
    wire rd_n = ce_n | oe_n;
    wire act = busy > 0 || win > 0; // status reads from the load on
    localparam logic [19:0] PRE = {10'h2aa, 10'h155};
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
    // read path; a released bus shows the inverse
    wire [7:0] rd = act ? {~last_d[7], tog, last_d[5:0]} : (idm || id_hv) &&
        addr[15:1] == 15'h0 ? (addr[0] ? PART : MAKER) : mem[addr];
    assign dq_in = rd_n ? ~held : rd;
    always @(negedge rd_n) if (act) tog = !tog;
    // store one page byte and restart the window
    task store;
        pbuf[la[6:0]] = dq_out;
        last_a = la;
        last_d = dq_out;
        win = WIN;
    endtask
    // address taken on the last falling strobe
    always @(negedge wr_n) begin
        la = addr;
        t0 = $realtime;
    end
    always @(posedge wr_n) if (dq_oe && $realtime - t0 >= 15.0) begin
        key = {la == 16'h5555, la == 16'h2aaa, dq_out};
        h = {h[49:0], key};
        if (busy > 0) begin
        end else if (win > 0) begin
            if (la[15:7] == last_a[15:7]) store;
        end else if (key[9:8] != 2'b0) begin
            if (h[29:10] == PRE && key[9]) case (dq_out)
                8'ha0: {prot, open} = 2'b11;
                8'h90: idm = 1'b1;
                8'hf0: idm = 1'b0;
                default: ;
            endcase
            if (h[59:40] == PRE && h[39:30] == 10'h280 && h[29:10] == PRE && key[9])
                case (dq_out)
                8'h20: prot = 1'b0;
                8'h60: idm = 1'b1;
                8'h10: begin
                    for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
                    last_d = 8'hff;
                    busy = 2 * PROG;
                end
                default: ;
            endcase
        // load opens only unprotected or after the preamble
        end else if (!prot || open) begin
            for (int i = 0; i < 128; i++) pbuf[i] = 8'hff;
            open = 1'b0;
            store;
        end
    end
    // window expiry programs the whole page at once
    always @(posedge clock) begin
        if (win > 0) begin
            win--;
            if (win == 0) begin
                for (int i = 0; i < 128; i++) mem[{last_a[15:7], i[6:0]}] = pbuf[i];
                busy = PROG;
            end
        end else if (busy > 0) busy--;
        if (!rd_n) held <= rd;
    end
endmodule // flash_dev_model

/* sim/flash_host_test.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_host_test import flash_host_pkg::*;;
    logic clock = 0, sys_rst = 1, cmd_valid = 0, cmd_protect = 0;
    logic byte_valid = 0, byte_last = 0;
    op_t cmd_op = OP_READ;
    logic [15:0] cmd_addr = 16'h0;
    logic [6:0] byte_offs = 7'h0;
    logic [7:0] byte_data = 8'h0;
    logic cmd_ready_r, byte_ready_r, done_r, timeout_r, dq_oe_r;
    logic ce_n_r, oe_n_r, we_n_r, id_hv_en_r;
    logic [7:0] rdata_r, dq_out_r, dq_in;
    logic [15:0] addr_r;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    int ref_mem [int]; // expected array contents
    bit ref_prot = 1, ref_id = 0;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary code
    localparam logic [7:0] PART = 8'h5a; // arbitrary code
    always #5 clock = ~clock;
    flash_host #(.WIN_CYC(200), .PAUSE_CYC(20), .PROG_CYC(5000), .ERASE_CYC(5000))
        flash_host_inst (.*);
    flash_dev_model #(.MAKER(MAKER), .PART(PART)) flash_dev_model_inst (.clock(clock),
        .addr(addr_r), .dq_out(dq_out_r), .dq_oe(dq_oe_r), .dq_in(dq_in), .ce_n(ce_n_r),
        .oe_n(oe_n_r), .we_n(we_n_r), .id_hv(id_hv_en_r));
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            test_done;
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [7:0] exp_rd(input int a);
        if (ref_id && a < 2) return a ? PART : MAKER;
        return ref_mem.exists(a) ? 8'(ref_mem[a]) : 8'hff;
    endfunction
    // offer a command and hold it until taken
    task run(input op_t op, input logic [15:0] a, input logic p);
        @(posedge clock);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_protect <= p;
        cmd_valid <= 1'b1;
        do @(negedge clock); while (cmd_ready_r !== 1'b1);
        @(posedge clock);
        cmd_valid <= 1'b0;
    endtask
    task finish_cmd;
        do @(negedge clock); while (done_r !== 1'b1);
        chk({7'h0, timeout_r}, 8'h0);
    endtask
    task rd_chk(input logic [15:0] a);
        run(OP_READ, a, 1'b0);
        finish_cmd;
        chk(rdata_r, exp_rd(a));
    endtask
    task send(input logic [6:0] o, input logic [7:0] d, input logic l);
        @(posedge clock);
        byte_offs <= o;
        byte_data <= d;
        byte_last <= l;
        byte_valid <= 1'b1;
        do @(negedge clock); while (byte_ready_r !== 1'b1);
        @(posedge clock);
        byte_valid <= 1'b0;
    endtask
    // random bytes at random offsets, then the whole page read back
    task page(input logic [15:0] pg, input logic p, input int nb, input logic fin);
        logic [6:0] o;
        logic [7:0] d;
        bit ok;
        ok = p || !ref_prot;
        run(OP_PAGE, pg, p);
        for (int i = 0; i < nb; i++) begin
            o = 7'($urandom_range(127));
            d = ok ? 8'($urandom) : 8'($urandom) | 8'h80;
            repeat ($urandom_range(100)) @(posedge clock);
            send(o, d, fin && i == nb - 1);
            if (ok) ref_mem[{pg[15:7], o}] = d;
        end
        if (p) ref_prot = 1;
        finish_cmd;
        chk(rdata_r, exp_rd({pg[15:7], o}));
        for (int i = 0; i < 128; i++) rd_chk({pg[15:7], 7'(i)});
        $display("page %h done", pg);
    endtask
    initial begin
        void'($urandom(53192));
        repeat (3) @(negedge clock);
        chk({2'h0, cmd_ready_r, ce_n_r, we_n_r, oe_n_r, dq_oe_r, id_hv_en_r}, 8'h3c);
        @(posedge clock);
        sys_rst <= 1'b0;
        for (int a = 0; a < 2; a++) begin
            run(OP_HWID, 16'(a), 1'b0);
            finish_cmd;
            chk(rdata_r, a ? PART : MAKER);
        end
        $display("hardware id done");
        page(16'h1000, 1'b0, 3, 1'b1);
        page(16'h2000, 1'b1, 6, 1'b1);
        page(16'h3000, 1'b0, 3, 1'b1);
        run(OP_UNPROT, 16'h0, 1'b0);
        finish_cmd;
        ref_prot = 0;
        page(16'h4000, 1'b0, 5, 1'b0);
        for (int k = 0; k < 2; k++) begin
            run(k ? OP_ID_ENTER6 : OP_ID_ENTER, 16'h0, 1'b0);
            finish_cmd;
            ref_id = 1;
            rd_chk(16'h0);
            rd_chk(16'h1);
            run(OP_ID_EXIT, 16'h0, 1'b0);
            finish_cmd;
            ref_id = 0;
            rd_chk(16'h0);
        end
        $display("software id done");
        run(OP_ERASE, 16'h0, 1'b0);
        finish_cmd;
        ref_mem.delete();
        for (int i = 0; i < 8; i++) rd_chk(16'h2000 + 16'($urandom_range(127)));
        $display("erase done");
        test_done;
    end
endmodule // flash_host_test
